// file: folr_pkg.sv
// Constants, types and helpers for the FIFO offset load and replay block.
// Assumes one write clock domain and one read clock domain using these.
`default_nettype none

package folr_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int              DW        = 18;
    localparam int              AW        = 17;
    localparam int              DEPTH     = 131072;
    localparam int              OW        = 17;
    localparam logic [AW:0]     DEPTH_CNT = 18'h20000;
    localparam logic [AW:0]     HALF_CNT  = 18'h10000;
    localparam logic [DW-1:0]   X9_MASK   = 18'h001ff;

    // ---------------------------------------------------------------
    // Offset sequencing
    // ---------------------------------------------------------------
    localparam logic [2:0]      OFS_N18   = 3'h4;
    localparam logic [2:0]      OFS_N9    = 3'h6;
    localparam logic [2:0]      HALF18    = 3'h2;
    localparam logic [2:0]      HALF9     = 3'h3;
    localparam logic [1:0]      PART0     = 2'h0;
    localparam logic [1:0]      PART1     = 2'h1;
    localparam logic [1:0]      PART2     = 2'h2;
    localparam int              LO18_W    = 16;
    localparam int              BYTE_W    = 8;
    localparam int              TOP_BIT   = 16;
    localparam logic [OW-1:0]   PAE_DEF   = 17'h0007f;
    localparam logic [OW-1:0]   PAF_DEF   = 17'h0007f;

    // Replay setup lasts SETUP_LAST+1 read clocks
    localparam logic [1:0]      SETUP_LAST = 2'h1;

    typedef enum logic {RD_RUN, RD_SETUP} folr_rd_state_t;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [AW:0] folr_b2g(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [AW:0] folr_g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic folr_is_full(input logic [2:0] idx, input logic x9);
        return idx >= (x9 ? HALF9 : HALF18);
    endfunction

    function automatic logic [1:0] folr_part(input logic [2:0] idx, input logic x9);
        logic [2:0] h;
        h = x9 ? HALF9 : HALF18;
        return (idx >= h) ? 2'(idx - h) : idx[1:0];
    endfunction

    function automatic logic folr_last_part(input logic [1:0] p, input logic x9);
        return p == (x9 ? PART2 : PART1);
    endfunction

    function automatic logic [2:0] folr_next(input logic [2:0] idx, input logic x9);
        return (idx == (x9 ? OFS_N9 : OFS_N18) - 3'h1) ? 3'h0 : 3'(idx + 3'h1);
    endfunction

    function automatic logic [OW-1:0] folr_ins(input logic [OW-1:0] old, input logic [DW-1:0] d,
                                               input logic [1:0] p, input logic x9);
        logic [OW-1:0] r;
        r = old;
        if (!x9 && p == PART0) begin
            r[LO18_W-1:0] = d[LO18_W-1:0];
        end else if (x9 && p == PART0) begin
            r[BYTE_W-1:0] = d[BYTE_W-1:0];
        end else if (x9 && p == PART1) begin
            r[2*BYTE_W-1:BYTE_W] = d[BYTE_W-1:0];
        end else begin
            r[TOP_BIT] = d[0];
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] folr_ext(input logic [OW-1:0] v, input logic [1:0] p,
                                               input logic x9);
        logic [DW-1:0] r;
        r = '0;
        if (!x9 && p == PART0) begin
            r[LO18_W-1:0] = v[LO18_W-1:0];
        end else if (x9 && p == PART0) begin
            r[BYTE_W-1:0] = v[BYTE_W-1:0];
        end else if (x9 && p == PART1) begin
            r[BYTE_W-1:0] = v[2*BYTE_W-1:BYTE_W];
        end else begin
            r[0] = v[TOP_BIT];
        end
        return r;
    endfunction

endpackage

`default_nettype wire

// file: folr_ctrl.sv
// Offset load/read-back and replay control for a dual-clock FIFO.
// Write pins are synchronous to I_MCLK, read pins to I_READ_CLK.
// What this block does
// - x9 to x9: six offset load writes
// - Eighteen-bit input four writes, nine-bit six
// - Load order: empty low/high, full low/high
// - Nine-bit adds one write per offset
// - Separate offset write and read pointers
// - Master reset clears offset pointers, partial keeps them
// - Load select high redirects writes to memory
// - Toggling write enable pauses offset loading
// - Flag invalid while its offset is partly loaded, then two edges
// - Load select, read enable low: offsets out
// - Eighteen-bit read-back empty, empty, full, full, wrap
// - Read-back pauses and resumes at next
// - Offset read overwrites output word
// - Read-back works in both timing modes
// - Replay depth fixed at DEPTH words for every width and mode
// - Standard: empty low during setup, pointer rewinds
// - Fall-through: ready high during setup, word appears
// - Almost-empty second edge, half-full setup edge
// - Zero latency loads first word same edge
// - Latency select latched during master reset
// - Load method latched during master reset
`timescale 1ns/1ps
`default_nettype none

module folr_ctrl (
    // Write clock and resets
    input  wire logic                   I_MCLK,
    input  wire logic                   I_SYS_RST,
    input  wire logic                   I_PART_RST,
    // Straps, caught during master reset
    input  wire logic                   I_IN_X9,
    input  wire logic                   I_OUT_X9,
    input  wire logic                   I_FALL_THROUGH_MODE,
    input  wire logic                   I_REPLAY_LATENCY_SELECT,
    input  wire logic                   I_SERIAL_LOAD_MODE,
    // Write port
    input  wire logic                   I_WRITE_EN_N,
    input  wire logic                   I_OFFSET_LOAD_SELECT_N,
    input  wire logic [folr_pkg::DW-1:0] I_DATA_IN_BUS,
    output logic                        O_ALMOST_FULL_FLAG_N,
    // Read port
    input  wire logic                   I_READ_CLK,
    input  wire logic                   I_READ_EN_N,
    input  wire logic                   I_REPLAY_REQUEST_N,
    output logic [folr_pkg::DW-1:0]     O_DATA_OUT_BUS,
    output logic                        O_EMPTY_FLAG_N,
    output logic                        O_OUTPUT_READY_N,
    output logic                        O_ALMOST_EMPTY_FLAG_N,
    output logic                        O_HALF_FULL_FLAG_N
);
    import folr_pkg::*;

    // ---------------------------------------------------------------
    // Storage and declarations
    // ---------------------------------------------------------------
    // Depth of replayable memory
    logic [DW-1:0]      mem [DEPTH];
    logic               in_x9_reg, out_x9_reg, fall_through_mode_reg, zlat_reg, serial_reg;
    logic [AW:0]        wptr_reg, wgray_reg, rg_w1, rg_w2, rptr_w, words_w;
    logic [OW-1:0]      e_off_reg, f_off_reg;
    logic [2:0]         wofs_idx_reg;
    logic               e_ok_reg, f_ok_reg, tog_reg;
    logic               f_ok_d_reg, af_hit_reg, af_n_reg;
    logic               wr_mem, ofs_wr;
    logic               mrst_s1, mrst_s2, prst_s1, prst_s2, lds_s1, lds_s2;
    logic               fall_through_mode_s1, fall_through_mode_s2, zlat_s1, zlat_s2, ox9_s1, ox9_s2;
    logic               tog_s1, tog_s2, tog_seen;
    logic [AW:0]        wg_s1, wg_s2, wptr_r, words_r, words_left, hf_words;
    logic [AW:0]        rptr_reg;
    logic [OW-1:0]      e_off_r, f_off_r;
    logic               e_ok_r, ae_hit_reg, pae_n_reg, hf_n_reg, ef_n_reg, or_n_reg;
    logic [2:0]         rofs_idx_reg;
    logic [1:0]         scnt_reg;
    folr_rd_state_t     state_reg;
    logic [DW-1:0]      dout_reg, first_word, ofs_ext_val;
    logic               rd_rst, avail, replay_go, ofs_rd, run_rd, mem_rd, setup_done;

    // ---------------------------------------------------------------
    // Write domain
    // ---------------------------------------------------------------
    // Straps sampled while master reset is high, held after it
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            in_x9_reg  <= I_IN_X9;
            out_x9_reg <= I_OUT_X9;
            fall_through_mode_reg   <= I_FALL_THROUGH_MODE;
            zlat_reg   <= ~I_REPLAY_LATENCY_SELECT;
            // Load method fixed until next master reset
            serial_reg <= I_SERIAL_LOAD_MODE;
        end
    end

    assign rptr_w  = folr_g2b(rg_w2);
    assign words_w = wptr_reg - rptr_w;
    // Load select high sends writes to memory
    assign wr_mem  = I_OFFSET_LOAD_SELECT_N & ~I_WRITE_EN_N & (words_w != DEPTH_CNT);
    // Serial loading is not built here, so it only locks out parallel loads
    assign ofs_wr  = ~I_OFFSET_LOAD_SELECT_N & ~I_WRITE_EN_N & ~serial_reg;

    always_ff @(posedge I_MCLK) begin
        if (wr_mem) begin
            mem[wptr_reg[AW-1:0]] <= in_x9_reg ? (I_DATA_IN_BUS & X9_MASK) : I_DATA_IN_BUS;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST || I_PART_RST) begin
            wptr_reg  <= '0;
            wgray_reg <= '0;
        end else if (wr_mem) begin
            wptr_reg  <= wptr_reg + 1'b1;
            wgray_reg <= folr_b2g(wptr_reg + 1'b1);
        end
    end

    // Partial reset deliberately absent: offsets and pointer survive it
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            e_off_reg    <= PAE_DEF;
            f_off_reg    <= PAF_DEF;
            e_ok_reg     <= 1'b1;
            f_ok_reg     <= 1'b1;
            // Master reset homes the load pointer
            wofs_idx_reg <= '0;
            tog_reg      <= 1'b0;
        end else if (ofs_wr) begin
            // Empty parts first, then full parts
            if (folr_is_full(wofs_idx_reg, in_x9_reg)) begin
                f_off_reg <= folr_ins(f_off_reg, I_DATA_IN_BUS, folr_part(wofs_idx_reg, in_x9_reg), in_x9_reg);
                f_ok_reg  <= folr_last_part(folr_part(wofs_idx_reg, in_x9_reg), in_x9_reg);
            end else begin
                e_off_reg <= folr_ins(e_off_reg, I_DATA_IN_BUS, folr_part(wofs_idx_reg, in_x9_reg), in_x9_reg);
                e_ok_reg  <= folr_last_part(folr_part(wofs_idx_reg, in_x9_reg), in_x9_reg);
            end
            // Sequence length set by input width
            // Nine-bit adds one part per offset
            wofs_idx_reg <= folr_next(wofs_idx_reg, in_x9_reg);
            tog_reg      <= ~tog_reg;
        end
    end

    // Read pointer into write domain
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST || I_PART_RST) begin
            rg_w1 <= '0;
            rg_w2 <= '0;
        end else begin
            rg_w1 <= folr_b2g(rptr_reg);
            rg_w2 <= rg_w1;
        end
    end

    // Two-stage almost-full path, held high while invalid
    // Rewound read pointer arrives via the synchroniser
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST || I_PART_RST) begin
            f_ok_d_reg <= 1'b0;
            af_hit_reg <= 1'b0;
            af_n_reg   <= 1'b1;
        end else begin
            f_ok_d_reg <= f_ok_reg;
            af_hit_reg <= words_w >= (DEPTH_CNT - {1'b0, f_off_reg});
            af_n_reg   <= ~(f_ok_d_reg & af_hit_reg);
        end
    end

    // ---------------------------------------------------------------
    // Read domain crossings
    // ---------------------------------------------------------------
    always_ff @(posedge I_READ_CLK) begin
        mrst_s1 <= I_SYS_RST;
        mrst_s2 <= mrst_s1;
        prst_s1 <= I_PART_RST;
        prst_s2 <= prst_s1;
        lds_s1  <= I_OFFSET_LOAD_SELECT_N;
        lds_s2  <= lds_s1;
        fall_through_mode_s1 <= fall_through_mode_reg;
        fall_through_mode_s2 <= fall_through_mode_s1;
        zlat_s1 <= zlat_reg;
        zlat_s2 <= zlat_s1;
        ox9_s1  <= out_x9_reg;
        ox9_s2  <= ox9_s1;
        tog_s1  <= tog_reg;
        tog_s2  <= tog_s1;
        wg_s1   <= wgray_reg;
        wg_s2   <= wg_s1;
    end

    assign rd_rst = mrst_s2 | prst_s2;

    // Offsets copied only after the toggle settles; host keeps them still
    always_ff @(posedge I_READ_CLK) begin
        if (mrst_s2) begin
            e_off_r  <= PAE_DEF;
            f_off_r  <= PAF_DEF;
            e_ok_r   <= 1'b1;
            tog_seen <= 1'b0;
        end else if (tog_s2 != tog_seen) begin
            tog_seen <= tog_s2;
            e_off_r  <= e_off_reg;
            f_off_r  <= f_off_reg;
            e_ok_r   <= e_ok_reg;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    assign wptr_r     = folr_g2b(wg_s2);
    assign words_r    = wptr_r - rptr_reg;
    assign avail      = words_r != '0;
    assign first_word = mem[{AW{1'b0}}];
    assign setup_done = (state_reg == RD_SETUP) && (scnt_reg == SETUP_LAST);
    // Replay taken on a low request at a read edge
    assign replay_go  = (state_reg == RD_RUN) && ~I_REPLAY_REQUEST_N;
    // Read-back only while both are low
    assign ofs_rd     = (state_reg == RD_RUN) && ~replay_go && ~lds_s2 && ~I_READ_EN_N;
    assign run_rd     = (state_reg == RD_RUN) && ~replay_go && lds_s2 && avail &&
                        (fall_through_mode_s2 ? (or_n_reg | ~I_READ_EN_N) : ~I_READ_EN_N);
    // Fall-through with normal latency loads first word at setup end
    assign mem_rd     = run_rd | (setup_done & fall_through_mode_s2 & ~zlat_s2 & avail);
    assign words_left = words_r - {{AW{1'b0}}, mem_rd};
    assign hf_words   = replay_go ? (wptr_r - {{AW{1'b0}}, zlat_s2}) : words_left;
    // Offset part shown on the output bus
    assign ofs_ext_val = folr_ext(folr_is_full(rofs_idx_reg, ox9_s2) ? f_off_r : e_off_r,
                                  folr_part(rofs_idx_reg, ox9_s2), ox9_s2);

    always_ff @(posedge I_READ_CLK) begin
        if (rd_rst) begin
            state_reg <= RD_RUN;
            scnt_reg  <= '0;
            rptr_reg  <= '0;
            dout_reg  <= '0;
        end else begin
            if (replay_go) begin
                state_reg <= RD_SETUP;
                scnt_reg  <= '0;
                // Zero latency: first word on this edge
                if (zlat_s2) begin
                    dout_reg <= first_word;
                    rptr_reg <= {{AW{1'b0}}, 1'b1};
                end else begin
                    // Read pointer back to first location
                    rptr_reg <= '0;
                end
            end else if (state_reg == RD_SETUP) begin
                scnt_reg <= scnt_reg + 2'h1;
                if (setup_done) begin
                    state_reg <= RD_RUN;
                end
            end
            // Offset read replaces the held word
            if (ofs_rd) begin
                dout_reg <= ofs_ext_val;
            end
            if (mem_rd) begin
                dout_reg <= mem[rptr_reg[AW-1:0]];
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end

    // Read-back pointer independent of load pointer
    always_ff @(posedge I_READ_CLK) begin
        if (mrst_s2) begin
            rofs_idx_reg <= '0;
        end else if (ofs_rd) begin
            // Wraps back to the empty offset
            rofs_idx_reg <= folr_next(rofs_idx_reg, ox9_s2);
        end
    end

    // ---------------------------------------------------------------
    // Read flags
    // ---------------------------------------------------------------
    // Empty flag low through setup
    always_ff @(posedge I_READ_CLK) begin
        if (rd_rst || fall_through_mode_s2 || replay_go) begin
            ef_n_reg <= 1'b0;
        end else if (state_reg == RD_SETUP) begin
            ef_n_reg <= setup_done & avail;
        end else begin
            ef_n_reg <= words_left != '0;
        end
    end

    always_ff @(posedge I_READ_CLK) begin
        if (rd_rst || ~fall_through_mode_s2 || replay_go) begin
            or_n_reg <= 1'b1;
        end else if (setup_done) begin
            or_n_reg <= ~(zlat_s2 | avail);
        end else if (state_reg == RD_RUN) begin
            if (mem_rd) begin
                or_n_reg <= 1'b0;
            end else if (~I_READ_EN_N && lds_s2) begin
                or_n_reg <= 1'b1;
            end
        end
    end

    // Almost-empty two edges on, half-full on setup edge
    // Almost-empty held low until its offset is complete
    always_ff @(posedge I_READ_CLK) begin
        if (rd_rst) begin
            ae_hit_reg <= 1'b0;
            pae_n_reg  <= 1'b0;
            hf_n_reg   <= 1'b1;
        end else begin
            ae_hit_reg <= e_ok_r & (words_r > {1'b0, e_off_r});
            pae_n_reg  <= ae_hit_reg;
            hf_n_reg   <= ~(hf_words > HALF_CNT);
        end
    end

    assign O_ALMOST_FULL_FLAG_N  = af_n_reg;
    assign O_DATA_OUT_BUS        = dout_reg;
    assign O_EMPTY_FLAG_N        = ef_n_reg;
    assign O_OUTPUT_READY_N      = or_n_reg;
    assign O_ALMOST_EMPTY_FLAG_N = pae_n_reg;
    assign O_HALF_FULL_FLAG_N    = hf_n_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_wofs_order: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        ofs_wr && !folr_is_full(wofs_idx_reg, in_x9_reg) |=> $stable(f_off_reg))
        else $error("empty offset load touched full offset");
    chk_wofs_count: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        ofs_wr && wofs_idx_reg == (in_x9_reg ? OFS_N9 : OFS_N18) - 3'h1 |=> wofs_idx_reg == 3'h0)
        else $error("offset load sequence length wrong");
    chk_wofs_pause: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        !ofs_wr |=> $stable(wofs_idx_reg))
        else $error("load pointer moved while paused");
    chk_mem_redirect: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST || I_PART_RST)
        ofs_wr |=> $stable(wptr_reg))
        else $error("offset load wrote memory");
    chk_rst_home: assert property (@(posedge I_MCLK)
        I_SYS_RST |=> wofs_idx_reg == 3'h0)
        else $error("master reset left load pointer");
    chk_af_invalid: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST || I_PART_RST)
        !f_ok_reg |-> ##2 af_n_reg)
        else $error("almost-full asserted while invalid");
    chk_rofs_wrap: assert property (@(posedge I_READ_CLK) disable iff (mrst_s2)
        ofs_rd && rofs_idx_reg == (ox9_s2 ? OFS_N9 : OFS_N18) - 3'h1 |=> rofs_idx_reg == 3'h0)
        else $error("read-back pointer failed to wrap");
    chk_rofs_out: assert property (@(posedge I_READ_CLK) disable iff (rd_rst)
        ofs_rd |=> dout_reg == $past(ofs_ext_val))
        else $error("offset not on output bus");
    chk_replay_ptr: assert property (@(posedge I_READ_CLK) disable iff (rd_rst)
        replay_go |=> rptr_reg == {{AW{1'b0}}, zlat_s2})
        else $error("replay did not rewind read pointer");
    chk_ef_setup: assert property (@(posedge I_READ_CLK) disable iff (rd_rst)
        replay_go && !fall_through_mode_s2 |=> !ef_n_reg [*2])
        else $error("empty flag high during setup");
    chk_or_setup: assert property (@(posedge I_READ_CLK) disable iff (rd_rst)
        replay_go && fall_through_mode_s2 |=> or_n_reg [*2])
        else $error("ready flag low during setup");
    chk_zlat_load: assert property (@(posedge I_READ_CLK) disable iff (rd_rst)
        replay_go && zlat_s2 |=> dout_reg == $past(first_word))
        else $error("zero latency word not loaded");

endmodule // folr_ctrl

`default_nettype wire

// file: folr_host_model.sv
// Read-side host model for the offset load and replay block.
// Assumes the bench supplies the read clock and drives the write side.
`timescale 1ns/1ps
`default_nettype none
module folr_host_model (
    // Read clock
    input  wire logic i_rclk,
    // Read pins
    output logic      o_ren_n,
    output logic      o_rt_n
);
    initial begin
        o_ren_n = 1'b1;
        o_rt_n  = 1'b1;
    end
    // Replay only after an idle read edge
    task automatic rd(input logic ren_n, input logic rt_n);
        if (!rt_n && !o_ren_n) begin
            @(negedge i_rclk);
            o_ren_n = 1'b1;
            @(posedge i_rclk);
        end
        @(negedge i_rclk);
        o_ren_n = ren_n;
        o_rt_n  = rt_n;
        @(posedge i_rclk);
        #1;
    endtask
endmodule // folr_host_model
`default_nettype wire

// file: folr_ctrl_bench.sv
// Bench for folr_ctrl in x18: standard/normal, then fall-through/zero latency.
// Assumes folr_host_model drives the read pins.
`timescale 1ns/1ps
`default_nettype none
module folr_ctrl_bench;
    import folr_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic          mclk  = 1'b0;
    logic          rclk  = 1'b0;
    logic          rst   = 1'b1;
    logic          prst  = 1'b0;
    logic          wen_n = 1'b1;
    logic          ld_n  = 1'b1;
    logic [DW-1:0] din   = '0;
    logic          fall_through_mode  = 1'b0;
    logic          rm    = 1'b1;
    logic          ren_n, rt_n, af_n, ef_n, or_n, ae_n, hf_n;
    logic [DW-1:0] dout;
    logic [DW-1:0] ofs [4] = '{18'h0abcd, 18'h00001, 18'h05432, 18'h00000};
    int            n_mismatch  = 0;
    int            check_count = 0;
    always #10 mclk = ~mclk;
    // Read clock, period unrelated to the write clock
    always #24 rclk = ~rclk;
    folr_ctrl folr_ctrl_i (
        .I_MCLK(mclk), .I_SYS_RST(rst), .I_PART_RST(prst),
        .I_IN_X9(1'b0), .I_OUT_X9(1'b0), .I_FALL_THROUGH_MODE(fall_through_mode),
        .I_REPLAY_LATENCY_SELECT(rm), .I_SERIAL_LOAD_MODE(1'b0),
        .I_WRITE_EN_N(wen_n), .I_OFFSET_LOAD_SELECT_N(ld_n),
        .I_DATA_IN_BUS(din), .O_ALMOST_FULL_FLAG_N(af_n),
        .I_READ_CLK(rclk), .I_READ_EN_N(ren_n), .I_REPLAY_REQUEST_N(rt_n),
        .O_DATA_OUT_BUS(dout), .O_EMPTY_FLAG_N(ef_n), .O_OUTPUT_READY_N(or_n),
        .O_ALMOST_EMPTY_FLAG_N(ae_n), .O_HALF_FULL_FLAG_N(hf_n));
    folr_host_model folr_host_model_i (.i_rclk(rclk), .o_ren_n(ren_n), .o_rt_n(rt_n));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wr(input logic ld, input logic [DW-1:0] d);
        @(negedge mclk);
        ld_n  = ld;
        wen_n = 1'b0;
        din   = d;
        @(negedge mclk);
        wen_n = 1'b1;
    endtask
    task automatic idle(input int n);
        repeat (n) folr_host_model_i.rd(1'b1, 1'b1);
    endtask
    task automatic chk_word(input logic [DW-1:0] exp);
        check_count++;
        if (dout !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t word %h exp %h", $time, dout, exp);
        end
    endtask
    task automatic rd(input logic [DW-1:0] exp);
        folr_host_model_i.rd(1'b0, 1'b1);
        chk_word(exp);
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait for stored data to reach the read side
    task automatic wait_data;
        for (int k = 0; k < 40 && (fall_through_mode ? ~or_n : ef_n) !== 1'b1; k++)
            idle(1);
        if ((fall_through_mode ? ~or_n : ef_n) !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH %0t no data", $time);
            complete_run();
        end
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        idle(5);
        // Load offsets, paused by a memory write
        wr(1'b0, ofs[0]);
        wr(1'b0, ofs[1]);
        wr(1'b1, 18'h00077);
        wr(1'b0, ofs[2]);
        wr(1'b0, ofs[3]);
        repeat (3) @(posedge mclk);
        chk_flag(af_n, 1'b1);
        @(negedge mclk);
        ld_n = 1'b1;
        idle(4);
        wait_data();
        rd(18'h00077);
        @(negedge mclk);
        ld_n = 1'b0;
        idle(4);
        // Read-back wraps and replaces the memory word
        for (int i = 0; i < 5; i++)
            rd(ofs[i % 4]);
        idle(1);
        @(negedge mclk);
        prst = 1'b1;
        repeat (10) @(negedge mclk);
        prst = 1'b0;
        idle(5);
        // Pointer kept over partial reset and pause
        rd(ofs[1]);
        @(negedge mclk);
        ld_n = 1'b1;
        idle(4);
        for (int i = 1; i < 5; i++)
            wr(1'b1, 18'(i));
        wait_data();
        rd(18'h00001);
        rd(18'h00002);
        idle(1);
        folr_host_model_i.rd(1'b1, 1'b0);
        chk_flag(ef_n, 1'b0);
        idle(2);
        chk_flag(ef_n, 1'b1);
        rd(18'h00001);
        rd(18'h00002);
        chk_flag(or_n, 1'b1);
        chk_flag(hf_n, 1'b1);
        chk_flag(ae_n, 1'b0);
        // Master reset again: fall-through, zero latency replay
        idle(1);
        @(negedge mclk);
        fall_through_mode = 1'b1;
        rm   = 1'b0;
        rst  = 1'b1;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        idle(5);
        for (int i = 5; i < 9; i++)
            wr(1'b1, 18'(i));
        wait_data();
        chk_word(18'h00005);
        rd(18'h00006);
        folr_host_model_i.rd(1'b0, 1'b0);
        chk_word(18'h00005);
        chk_flag(or_n, 1'b1);
        idle(2);
        chk_flag(or_n, 1'b0);
        rd(18'h00006);
        @(negedge mclk);
        ld_n = 1'b0;
        idle(4);
        rd(DW'(PAE_DEF));
        complete_run();
    end
endmodule // folr_ctrl_bench
`default_nettype wire
